/* File: hw/ewc_consts.svh */
// Constants for the extension word address calculator
`ifndef EWC_CONSTS_SVH
`define EWC_CONSTS_SVH
// Brief and full extension word field positions
`define EWC_IDX_TYPE_BIT      15
`define EWC_IDX_REG_HI        14
`define EWC_IDX_REG_LO        12
`define EWC_IDX_SIZE_BIT      11
`define EWC_SCALE_HI          10
`define EWC_SCALE_LO          9
`define EWC_FULL_BIT          8
`define EWC_DISP8_HI          7
`define EWC_BS_BIT            7
`define EWC_IS_BIT            6
`define EWC_BD_SIZE_HI        5
`define EWC_BD_SIZE_LO        4
`define EWC_IIS_HI            2
`define EWC_IIS_LO            0
// Effective address field: mode bits 5..3, register bits 2..0
`define EWC_EA_MODE_HI        5
`define EWC_EA_MODE_LO        3
`define EWC_EA_REG_HI         2
`define EWC_EA_REG_LO         0
`define EWC_EA_PC_MODE        3'h7
`define EWC_EA_PC_REG         3'h3
// Displacement size codes
`define EWC_SZ_NULL           2'h1
`define EWC_SZ_WORD           2'h2
`define EWC_SZ_LONG           2'h3
// Reset values
`define EWC_RESET_ADDR        32'h0000_0000
`endif

/* File: hw/ewc_pkg.sv */
// Types for the extension word address calculator
package ewc_pkg;
    // Top-level sequencer states
    typedef enum logic [3:0] {
        EWC_IDLE,
        EWC_FETCH_EXT,
        EWC_FETCH_BD_HI,
        EWC_FETCH_BD_LO,
        EWC_FETCH_OD_HI,
        EWC_FETCH_OD_LO,
        EWC_PTR_ADDR,
        EWC_PTR_READ,
        EWC_FINAL,
        EWC_DONE
    } ewc_state_type;
    // Address form selected by the indirect/index select field
    typedef enum logic [1:0] {
        EWC_FORM_NO_INDIRECT,
        EWC_FORM_PREINDEX,
        EWC_FORM_POSTINDEX,
        EWC_FORM_RESERVED
    } ewc_form_type;
endpackage : ewc_pkg

/* File: hw/ewc_index_unit.sv */
// Index contribution: size, sign extension and scaling
`timescale 1ns/1ps
`include "ewc_consts.svh"
module ewc_index_unit (
    // Index source
    input  wire logic [31:0] index_register,     // Selected index register contents
    input  wire logic        index_long,         // High: full long word index
    input  wire logic [1:0]  scale,              // Scale field
    input  wire logic        legacy_mode,        // High: older unscaled decoding
    input  wire logic        index_suppress,     // High: index contributes zero
    // Result
    output logic      [31:0] index_term          // Contribution to the address sum
);
    import ewc_pkg::*;
    // Sized and scaled index; the source register is never altered
    always_comb begin
        logic [31:0] sized;
        logic [1:0]  eff_scale;
        sized     = index_long ? index_register
                               : {{16{index_register[15]}}, index_register[15:0]};
        eff_scale = legacy_mode ? 2'h0 : scale;
        if (index_suppress) begin
            index_term = 32'h0000_0000;
        end else begin
            index_term = sized << eff_scale;
        end
    end
endmodule : ewc_index_unit

/* File: hw/ewc_ea_calc.sv */
// Extension word decoder and effective address calculator
`timescale 1ns/1ps
`include "ewc_consts.svh"
// Behaviour
// - Zero scale decodes alike in both formats
// - Legacy variant ignores nonzero scale bits
// - Legacy variant never traps unknown encodings
// - Each full-format element suppressible independently
// - Suppressed element contributes zero
// - Base suppress bit controls base element
// - EA field picks PC or address register
// - PC base equals extension word address
// - Index size bit picks word or long
// - Scale multiplies index by one to eight
// - Displacements word or long; outer from select
// - Outer displacement only in memory indirect
// - No-indirect sum: base, index, displacement
// - Indirect forms do one memory read
// - Preindex adds index before pointer read
// - Postindex adds index after pointer read
module ewc_ea_calc (
    // Clock and reset
    input  wire logic        ref_clk,            // Core clock
    input  wire logic        reset,              // Asynchronous, active high
    // Request
    input  wire logic        start,              // Begin a calculation
    input  wire logic [5:0]  ea_field,           // Effective address field of opcode
    input  wire logic [31:0] ext_word_addr,      // Address of the extension word
    input  wire logic        legacy_mode,        // High: older brief decoding
    // Register file read
    input  wire logic [31:0] selected_address_register, // Contents of base address register
    input  wire logic [31:0] index_register,     // Contents of indexed register
    output logic      [3:0]  index_reg_select,   // {type, number} of index register
    // Instruction stream
    input  wire logic        stream_valid,       // Next stream word present
    input  wire logic [15:0] stream_word,        // Next stream word
    output logic             stream_ready,       // Stream word taken
    // Operand memory
    output logic             mem_req,            // Pointer read request
    output logic      [31:0] mem_addr,           // Pointer read address
    input  wire logic        mem_ack,            // Pointer read done
    input  wire logic [31:0] mem_rdata,          // Intermediate pointer value
    // Result
    output logic             done,               // One-cycle result pulse
    output logic      [31:0] operand_addr,       // Final operand address
    output logic             busy                // Calculation in progress
);
    import ewc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State
    ewc_state_type state;                        // Sequencer state
    logic [15:0]   ext;                          // Captured extension word
    logic [5:0]    ea;                           // Captured EA field
    logic [31:0]   pc_base;                      // Extension word address
    logic [31:0]   base_displacement;            // Sign-extended base displacement
    logic [31:0]   outer_displacement;           // Sign-extended outer displacement
    logic [31:0]   intermediate_pointer;         // Pointer read from memory
    logic [31:0]   index_term;                   // Scaled index contribution
    logic          legacy;                       // Captured decoding variant

    ////////////////////////////////////////////////////////////////////////////
    // Decoding functions

    // Size code to a word count of extra fetches
    function automatic logic [1:0] size_words(input logic [1:0] code);
        unique case (code)
            `EWC_SZ_WORD: size_words = 2'h1;
            `EWC_SZ_LONG: size_words = 2'h2;
            default:      size_words = 2'h0;     // Null or reserved: suppressed
        endcase
    endfunction : size_words

    // Sign extend a word displacement
    function automatic logic [31:0] sext16(input logic [15:0] w);
        sext16 = {{16{w[15]}}, w};
    endfunction : sext16

    // Full format is used only by the newer decoding
    wire        full_fmt      = ext[`EWC_FULL_BIT] && !legacy;
    wire        base_suppress_bit = full_fmt && ext[`EWC_BS_BIT];
    wire        index_supp    = full_fmt && ext[`EWC_IS_BIT];
    wire [1:0]  bd_size       = ext[`EWC_BD_SIZE_HI:`EWC_BD_SIZE_LO];
    wire [2:0]  indirect_index_select = ext[`EWC_IIS_HI:`EWC_IIS_LO];
    wire [1:0]  od_size       = indirect_index_select[1:0];
    wire        pc_rel        = (ea[`EWC_EA_MODE_HI:`EWC_EA_MODE_LO] == `EWC_EA_PC_MODE) &&
                                (ea[`EWC_EA_REG_HI:`EWC_EA_REG_LO] == `EWC_EA_PC_REG);

    // Form: no indirect when select low bits zero, else pre or post index
    function automatic ewc_form_type form_of(input logic full, input logic [2:0] iis);
        if (!full || iis[1:0] == 2'h0) begin
            form_of = EWC_FORM_NO_INDIRECT;
        end else if (!iis[2]) begin
            form_of = EWC_FORM_PREINDEX;
        end else begin
            form_of = EWC_FORM_POSTINDEX;        // Index suppressed handled by index_supp
        end
    endfunction : form_of

    wire ewc_form_type form = form_of(full_fmt, indirect_index_select);

    // Base element: PC, address register, or zero
    wire [31:0] base_element = base_suppress_bit ? 32'h0000_0000
                             : pc_rel ? pc_base
                             : selected_address_register;

    ////////////////////////////////////////////////////////////////////////////
    // Index unit
    ewc_index_unit u_index (
        .index_register (index_register),
        .index_long     (ext[`EWC_IDX_SIZE_BIT]),
        .scale          (ext[`EWC_SCALE_HI:`EWC_SCALE_LO]),
        .legacy_mode    (legacy),
        .index_suppress (index_supp),
        .index_term     (index_term)
    );

    assign index_reg_select = ext[`EWC_IDX_TYPE_BIT:`EWC_IDX_REG_LO];

    ////////////////////////////////////////////////////////////////////////////
    // Sums
    wire [31:0] brief_disp = {{24{ext[`EWC_DISP8_HI]}}, ext[7:0]};
    wire [31:0] disp_term  = full_fmt ? base_displacement : brief_disp;
    wire [31:0] pre_idx    = (form == EWC_FORM_POSTINDEX) ? 32'h0000_0000 : index_term;
    wire [31:0] first_sum  = base_element + pre_idx + disp_term;
    wire [31:0] post_idx   = (form == EWC_FORM_POSTINDEX) ? index_term : 32'h0000_0000;
    wire [31:0] second_sum = intermediate_pointer + post_idx + outer_displacement;

    ////////////////////////////////////////////////////////////////////////////
    // Handshake outputs
    assign stream_ready = stream_valid && (state == EWC_FETCH_EXT || state == EWC_FETCH_BD_HI ||
                          state == EWC_FETCH_BD_LO || state == EWC_FETCH_OD_HI ||
                          state == EWC_FETCH_OD_LO);
    assign mem_req      = (state == EWC_PTR_READ);
    assign busy         = (state != EWC_IDLE);
    assign done         = (state == EWC_DONE);

    ////////////////////////////////////////////////////////////////////////////
    // Next state after displacement fetches
    function automatic ewc_state_type after_bd(input ewc_form_type f, input logic [1:0] osz);
        if (f == EWC_FORM_NO_INDIRECT) begin
            after_bd = EWC_FINAL;
        end else if (size_words(osz) != 2'h0) begin
            after_bd = EWC_FETCH_OD_HI;
        end else begin
            after_bd = EWC_PTR_ADDR;
        end
    endfunction : after_bd

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state <= EWC_IDLE;
        end else begin
            unique case (state)
                EWC_IDLE: begin
                    if (start) begin
                        state <= EWC_FETCH_EXT;
                    end
                end
                EWC_FETCH_EXT: begin
                    if (stream_valid) begin
                        if (stream_word[`EWC_FULL_BIT] && !legacy) begin
                            if (size_words(stream_word[`EWC_BD_SIZE_HI:`EWC_BD_SIZE_LO]) != 2'h0) begin
                                state <= EWC_FETCH_BD_HI;
                            end else begin
                                state <= after_bd(form_of(1'b1, stream_word[`EWC_IIS_HI:`EWC_IIS_LO]),
                                                  stream_word[1:0]);
                            end
                        end else begin
                            state <= EWC_FINAL;  // Brief format, never traps
                        end
                    end
                end
                EWC_FETCH_BD_HI: begin
                    if (stream_valid) begin
                        state <= (size_words(bd_size) == 2'h2) ? EWC_FETCH_BD_LO : after_bd(form, od_size);
                    end
                end
                EWC_FETCH_BD_LO: begin
                    if (stream_valid) begin
                        state <= after_bd(form, od_size);
                    end
                end
                EWC_FETCH_OD_HI: begin
                    if (stream_valid) begin
                        state <= (size_words(od_size) == 2'h2) ? EWC_FETCH_OD_LO : EWC_PTR_ADDR;
                    end
                end
                EWC_FETCH_OD_LO: begin
                    if (stream_valid) begin
                        state <= EWC_PTR_ADDR;
                    end
                end
                EWC_PTR_ADDR: state <= EWC_PTR_READ;
                EWC_PTR_READ: begin
                    if (mem_ack) begin
                        state <= EWC_FINAL;
                    end
                end
                EWC_FINAL: state <= EWC_DONE;
                EWC_DONE:  state <= EWC_IDLE;
                default:   state <= EWC_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request capture
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ea      <= 6'h00;
            pc_base <= `EWC_RESET_ADDR;
            legacy  <= 1'b0;
        end else if (state == EWC_IDLE && start) begin
            ea      <= ea_field;
            pc_base <= ext_word_addr;
            legacy  <= legacy_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Extension word and displacement capture
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ext                <= 16'h0000;
            base_displacement  <= 32'h0000_0000;
            outer_displacement <= 32'h0000_0000;
        end else if (stream_ready) begin
            unique case (state)
                EWC_FETCH_EXT: begin
                    ext                <= stream_word;
                    base_displacement  <= 32'h0000_0000;
                    outer_displacement <= 32'h0000_0000;
                end
                EWC_FETCH_BD_HI: begin
                    base_displacement <= (size_words(bd_size) == 2'h2) ? {stream_word, 16'h0000}
                                                                       : sext16(stream_word);
                end
                EWC_FETCH_BD_LO: base_displacement <= {base_displacement[31:16], stream_word};
                EWC_FETCH_OD_HI: begin
                    outer_displacement <= (size_words(od_size) == 2'h2) ? {stream_word, 16'h0000}
                                                                        : sext16(stream_word);
                end
                EWC_FETCH_OD_LO: outer_displacement <= {outer_displacement[31:16], stream_word};
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pointer address and pointer value
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mem_addr             <= `EWC_RESET_ADDR;
            intermediate_pointer <= `EWC_RESET_ADDR;
        end else begin
            if (state == EWC_PTR_ADDR) begin
                mem_addr <= first_sum;
            end
            if (state == EWC_PTR_READ && mem_ack) begin
                intermediate_pointer <= mem_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Final operand address
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            operand_addr <= `EWC_RESET_ADDR;
        end else if (state == EWC_FINAL) begin
            operand_addr <= (form == EWC_FORM_NO_INDIRECT) ? first_sum
                                                           : second_sum;
        end
    end
endmodule : ewc_ea_calc

/* File: tb/ewc_ea_calc_sva.sv */
// Port checker for the extension word address calculator
`timescale 1ns/1ps
module ewc_ea_calc_sva (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // Request and result
    input  wire logic        start,
    input  wire logic        busy,
    input  wire logic        done,
    input  wire logic [31:0] operand_addr,
    // Stream and memory
    input  wire logic        stream_valid,
    input  wire logic        stream_ready,
    input  wire logic        mem_req,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_addr
);
    ////////////////////////////////////////////////////////////////////////
    // One clock domain, so one clocking and one reset for all properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_start_goes_busy: assert property (start && !busy |=> busy)
        else $error("start in idle did not raise busy");
    a_done_one_pulse: assert property (done |-> busy ##1 (!done && !busy))
        else $error("done not a single pulse ending the calculation");
    a_result_holds: assert property (!done |-> $stable(operand_addr))
        else $error("operand address moved without done");
    a_ptr_addr_stable: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("pointer request dropped or address moved before ack");
    a_ptr_then_done: assert property (mem_req && mem_ack |=> !mem_req ##1 done)
        else $error("pointer read not followed by release and result");
    a_stream_gated: assert property (stream_ready |-> stream_valid && busy && !$past(mem_req) && !$past(done))
        else $error("stream word taken without valid or outside a calculation");
    a_idle_quiet: assert property (!busy |-> (!mem_req && !done) ##1 ($past(start) || !busy))
        else $error("memory request or result while idle");
    a_busy_bounded: assert property ($rose(busy) |-> ##[2:60] done)
        else $error("calculation did not finish in bound");
endmodule : ewc_ea_calc_sva

bind ewc_ea_calc ewc_ea_calc_sva i_sva (.ref_clk(ref_clk), .reset(reset), .start(start), .busy(busy),
    .done(done), .operand_addr(operand_addr), .stream_valid(stream_valid), .stream_ready(stream_ready),
    .mem_req(mem_req), .mem_ack(mem_ack), .mem_addr(mem_addr));

/* File: tb/ewc_far_side.sv */
// Model of the instruction stream and the operand memory
`timescale 1ns/1ps
module ewc_far_side (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // Pace controls
    input  wire logic        slow,
    input  wire logic [3:0]  ack_delay,
    // Instruction stream
    output logic             stream_valid,
    output logic      [15:0] stream_word,
    input  wire logic        stream_ready,
    // Operand memory
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    output logic             mem_ack,
    output logic      [31:0] mem_rdata
);
    logic [15:0] words[$];   // Words waiting to be offered
    logic [3:0]  wait_cnt;   // Cycles a pointer read has waited
    logic        pace;       // Alternates when the stream is slow
    // Queue a word for the stream
    task push_word(input logic [15:0] w);
        words.push_back(w);
    endtask : push_word
    ////////////////////////////////////////////////////////////////////////
    // Stream: hold an offered word until taken, scramble the bus when idle
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            stream_valid <= 1'b0;
            stream_word  <= 16'h0;
            pace         <= 1'b0;
        end else if (!(stream_valid && !stream_ready)) begin
            if (stream_valid) void'(words.pop_front());
            pace <= ~pace;
            if (words.size() > 0 && (!slow || pace)) begin
                stream_valid <= 1'b1;
                stream_word  <= words[0];
            end else begin
                stream_valid <= 1'b0;
                stream_word  <= ~stream_word;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Memory: answer a pointer read after a set wait, data only with ack
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mem_ack   <= 1'b0;
            mem_rdata <= 32'h0;
            wait_cnt  <= 4'h0;
        end else if (mem_ack) begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_cnt  <= 4'h0;
        end else if (mem_req && wait_cnt == ack_delay) begin
            mem_ack   <= 1'b1;
            mem_rdata <= mem_addr ^ 32'h3c3c_0f0f;
        end else begin
            wait_cnt  <= mem_req ? wait_cnt + 4'h1 : 4'h0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule : ewc_far_side

/* File: tb/ewc_ea_calc_tb.sv */
// Self-checking bench for the extension word address calculator
`timescale 1ns/1ps
module ewc_ea_calc_tb;
    logic        ref_clk = 1'b0;                   // Core clock
    logic        reset, start, legacy_mode, slow;  // Controls
    logic [5:0]  ea_field;                         // Opcode address field
    logic [31:0] ext_word_addr, selected_address_register, index_register;
    logic [3:0]  index_reg_select, ack_delay;      // Register pick, memory wait
    logic        stream_valid, stream_ready, mem_req, mem_ack, done, busy;
    logic [15:0] stream_word;                      // Stream word
    logic [31:0] mem_addr, mem_rdata, operand_addr;
    logic [31:0] xregs[16];                        // Register file contents
    logic [31:0] an_val, pc_val, bdv, odv, r, seed; // Current operands and random state
    logic [31:0] exp_q[$];                         // Expected results in order
    int          fails, checks_done;               // Verdict counters
    always #2.5 ref_clk = ~ref_clk;
    assign index_register = xregs[index_reg_select];
    ewc_ea_calc i_dut (.ref_clk(ref_clk), .reset(reset), .start(start), .ea_field(ea_field),
        .ext_word_addr(ext_word_addr), .legacy_mode(legacy_mode),
        .selected_address_register(selected_address_register), .index_register(index_register),
        .index_reg_select(index_reg_select), .stream_valid(stream_valid), .stream_word(stream_word),
        .stream_ready(stream_ready), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .done(done), .operand_addr(operand_addr), .busy(busy));
    ewc_far_side i_far (.ref_clk(ref_clk), .reset(reset), .slow(slow), .ack_delay(ack_delay),
        .stream_valid(stream_valid), .stream_word(stream_word), .stream_ready(stream_ready),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    ////////////////////////////////////////////////////////////////////////
    // Helpers: random source, sign extension, displacement size
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic logic [31:0] sx16(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction : sx16
    function automatic logic [31:0] disp_val(input logic [1:0] sz, input logic [31:0] v);
        return (sz == 2'h3) ? v : (sz == 2'h2) ? sx16(v[15:0]) : 32'h0;
    endfunction : disp_val
    // Reference address for one extension word
    function automatic logic [31:0] expect_addr(input logic [5:0] ea, input logic [15:0] ext, input logic lg);
        logic [31:0] base, x, b, p;
        base = (ea == 6'h3b) ? pc_val : an_val;
        x = xregs[ext[15:12]];
        if (!ext[11]) x = sx16(x[15:0]);
        if (lg || !ext[8]) return base + (x << (lg ? 2'h0 : ext[10:9])) + {{24{ext[7]}}, ext[7:0]};
        if (ext[7]) base = 32'h0;
        if (ext[6]) x = 32'h0;
        x = x << ext[10:9];
        b = base + disp_val(ext[5:4], bdv);
        if (ext[1:0] == 2'h0) return b + x;
        p = ext[2] ? b : b + x;
        return (p ^ 32'h3c3c_0f0f) + disp_val(ext[1:0], odv) + (ext[2] ? x : 32'h0);
    endfunction : expect_addr
    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task check_val(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, seen);
            fails++;
        end
    endtask : check_val
    task end_of_test;
        if (fails == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    // Fresh register, displacement and selector values
    task new_values;
        for (int k = 0; k < 16; k++) begin
            seed = lfsr_next(seed);
            xregs[k] = seed;
        end
        seed = lfsr_next(seed); an_val = seed;
        seed = lfsr_next(seed); pc_val = seed;
        seed = lfsr_next(seed); bdv = seed;
        seed = lfsr_next(seed); odv = seed;
        seed = lfsr_next(seed); r = seed;
    endtask : new_values
    // Queue a displacement, high half first for long
    task push_disp(input logic [1:0] sz, input logic [31:0] v);
        if (sz == 2'h3) i_far.push_word(v[31:16]);
        if (sz[1]) i_far.push_word(v[15:0]);
    endtask : push_disp
    // One calculation: note the result, feed words, pulse start, wait for idle
    task run_op(input logic [5:0] ea, input logic [15:0] ext, input logic lg);
        int n;
        exp_q.push_back(expect_addr(ea, ext, lg));
        i_far.push_word(ext);
        if (ext[8] && !lg) begin
            push_disp(ext[5:4], bdv);
            if (ext[1:0] != 2'h0) push_disp(ext[1:0], odv);
        end
        @(posedge ref_clk);
        start <= 1'b1; ea_field <= ea; legacy_mode <= lg;
        selected_address_register <= an_val; ext_word_addr <= pc_val;
        @(posedge ref_clk);
        start <= 1'b0;
        for (n = 0; n < 200; n++) begin
            @(posedge ref_clk);
            #1;
            if (busy === 1'b0) break;
        end
        if (n == 200) begin
            fails++;
            end_of_test();
        end
    endtask : run_op
    ////////////////////////////////////////////////////////////////////////
    // Watcher: each result is matched to the oldest note
    always @(negedge ref_clk) begin
        if (done === 1'b1) begin
            if (exp_q.size() > 0) check_val("operand_addr", operand_addr, exp_q.pop_front());
            else check_val("spare done", 32'h1, 32'h0);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        reset = 1'b1; start = 1'b0; legacy_mode = 1'b0; ea_field = 6'h0; slow = 1'b0; ack_delay = 4'h0;
        ext_word_addr = 32'h0; selected_address_register = 32'h0; seed = 32'h0711;
        fails = 0; checks_done = 0;
        new_values();
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        // Brief words, both decoders, every scale, both index sizes
        for (int i = 0; i < 16; i++) begin
            new_values();
            run_op({3'h6, r[18:16]}, {r[15:12], i[0], i[2:1], i[3], r[7:0]}, i[3]);
        end
        // Program counter as base
        for (int i = 0; i < 4; i++) begin
            new_values();
            run_op(6'h3b, {r[15:12], i[0], r[10:9], 1'b0, r[7:0]}, i[1]);
        end
        // Full words, no indirection, every suppression mix and size except base and index suppressed with null displacement
        for (int i = 4; i < 16; i++) begin
            if (i[3:0] == 4'h7) continue;
            new_values();
            run_op(r[17] ? 6'h3b : {3'h6, r[18:16]}, {r[15:9], 1'b1, i[0], i[1], i[3:2], 1'b0, r[19], 2'h0},
                   1'b0);
        end
        // Full words, memory indirect, pre and post, every outer size, far side fast and slow
        for (int i = 0; i < 16; i++) begin
            if (i[1:0] == 2'h0) continue;
            new_values();
            slow = i[3];
            ack_delay = r[23:20];
            run_op(r[17] ? 6'h3b : {3'h6, r[18:16]}, {r[15:9], 1'b1, r[24], r[25], 1'b1, r[26], 1'b0, i[2:0]},
                   1'b0);
        end
        check_val("pending results", exp_q.size(), 32'h0);
        end_of_test();
    end
endmodule : ewc_ea_calc_tb
